// file: design/smc_pkg.sv
// Package for the system mode control register bank.
// Assumes an APB slave with 32-bit data and one register per aligned word.
package smc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Printed offsets are not multiples of four: kept as indices
  localparam logic [15:0] SYSCTL_IDX = 16'hffc4;
  localparam logic [15:0] MODERB_IDX = 16'hffc5;
  localparam logic [17:0] SYSCTL_ADDR = {SYSCTL_IDX, 2'b00};
  localparam logic [17:0] MODERB_ADDR = {MODERB_IDX, 2'b00};

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int STBY_BIT = 7;
  localparam int STS_LSB = 4;
  localparam int NMI_EDGE_SELECT_BIT = 2;
  localparam int ONCHIP_RAM_ENABLE_BIT = 0;
  localparam logic [7:0] SYSCTL_RST = 8'h0b;
  localparam logic [7:0] SYSCTL_WMASK = 8'hf5;
  localparam logic [7:0] SYSCTL_ONES = 8'h0a;
  localparam logic [7:0] MODERB_FIXED = 8'he4;

  // ----------------------------------------------------------------
  // Settling counts in states
  // ----------------------------------------------------------------
  localparam int SETTLE_0 = 8192;
  localparam int SETTLE_1 = 16384;
  localparam int SETTLE_2 = 32768;
  localparam int SETTLE_3 = 65536;
  localparam int SETTLE_4 = 131072;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SMC_RUN = 2'b00,
    SMC_SLEEP = 2'b01,
    SMC_STBY = 2'b11,
    SMC_SETTLE = 2'b10
  } smc_pwr_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
  } smc_apb_req_t;

  typedef struct packed {
    logic standby_select;
    logic [2:0] settle_sel;
    logic nmi_edge_select;
    logic onchip_ram_enable;
  } smc_ctl_t;

endpackage : smc_pkg

// file: design/smc_regs.sv
// System mode control registers: control and mode readback.
// Assumes pclk at 125 MHz, APB master, mode pins and NMI from pins.
`timescale 1ns/1ns

// Functional notes
// - Sleep instruction enters sleep with standby select 0, software standby with 1.
// - Standby select stays 1 after interrupt wake-up and clears only by a 0 write.
// - Settle field 0..3 gives 8192..65536 states, top bit set gives 131072.
// - After interrupt wake-up from standby, cpu_hold keeps the CPU waiting for the settle time.
// - Control bits 3 and 1 read 1 and ignore writes.
// - NMI is requested on a falling edge with edge select 0, rising with 1.
// - The on-chip RAM is enabled exactly while the RAM enable bit is 1.
// - RAM enable resets to 1 and keeps its value through standby.
// - Mode register bits 7..5 and 2 read 1, bits 4..3 read 0, writes ignored.
// - Mode pins appear in bits 1 and 0, high pin in bit 1, read-only.
// - Each mode register read latches the current mode pin levels.
// - Reset clears the latched mode bits; the first edge after release loads the mode pin levels.
// - Mode 01 expanded without ROM, 10 expanded with ROM, 11 single-chip, 00 illegal.
// - Expanded mode with RAM disabled routes on-chip RAM range off chip.
module smc_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire smc_pkg::smc_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic mode_pin_hi,
  input wire logic mode_pin_lo,
  input wire logic nmi_pin,
  // CPU side
  input wire logic sleep_exec,
  input wire logic ext_irq_wake,
  input wire logic ram_range_hit,
  output logic nmi_req,
  output logic cpu_hold,
  output logic sleep_mode,
  output logic stby_mode,
  output logic onchip_ram_en,
  output logic ram_route_ext,
  output logic rom_enable,
  output logic expanded_mode,
  output logic mode_illegal
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic nmi_prev_r;
  logic rst_seen_r;

  // No reset: pins settle during reset, so the latch sees real levels at release
  always_ff @(posedge pclk) begin
    sync1_r <= {mode_pin_hi, mode_pin_lo, nmi_pin};
    sync2_r <= sync1_r;
  end

  wire [1:0] mode_pins_s = sync2_r[2:1];
  wire nmi_s = sync2_r[0];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire acc = apb_req.psel && apb_req.penable;
  wire hit_ctl = apb_req.paddr == smc_pkg::SYSCTL_ADDR;
  wire hit_mode = apb_req.paddr == smc_pkg::MODERB_ADDR;
  wire wr_ctl = acc && apb_req.pwrite && hit_ctl;
  wire rd_mode = acc && !apb_req.pwrite && hit_mode;

  assign pready = 1'b1;
  assign pslverr = acc && !hit_ctl && !hit_mode;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  logic [1:0] mode_r;
  smc_pkg::smc_pwr_t pwr_r;
  smc_pkg::smc_pwr_t pwr_nxt;

  // Only writable bits change; reserved ones forced to one
  always_comb begin
    ctl_nxt = ctl_r;
    if (wr_ctl) begin
      ctl_nxt = (ctl_r & ~smc_pkg::SYSCTL_WMASK)
        | (apb_req.pwdata[7:0] & smc_pkg::SYSCTL_WMASK);
    end
    ctl_nxt = ctl_nxt | smc_pkg::SYSCTL_ONES;
  end

  // Standby never touches this register, so RAM enable survives it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= smc_pkg::SYSCTL_RST;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  smc_pkg::smc_ctl_t ctl;
  assign ctl.standby_select = ctl_r[smc_pkg::STBY_BIT];
  assign ctl.settle_sel = ctl_r[smc_pkg::STS_LSB +: 3];
  assign ctl.nmi_edge_select = ctl_r[smc_pkg::NMI_EDGE_SELECT_BIT];
  assign ctl.onchip_ram_enable = ctl_r[smc_pkg::ONCHIP_RAM_ENABLE_BIT];

  // ----------------------------------------------------------------
  // Mode readback
  // ----------------------------------------------------------------
  // Pins caught on the first edge after release and on each read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= 2'h0;
      rst_seen_r <= 1'b0;
    end else begin
      rst_seen_r <= 1'b1;
      if (!rst_seen_r || rd_mode) begin
        mode_r <= mode_pins_s;
      end
    end
  end

  wire [7:0] mode_rd = smc_pkg::MODERB_FIXED | {6'h00, mode_pins_s};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      prdata <= hit_ctl ? {24'h0, ctl_r} : hit_mode ? {24'h0, mode_rd} : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Mode decode and RAM routing
  // ----------------------------------------------------------------
  assign mode_illegal = mode_r == 2'b00;
  assign expanded_mode = mode_r == 2'b01 || mode_r == 2'b10;
  assign rom_enable = mode_r[1];
  assign onchip_ram_en = ctl.onchip_ram_enable;
  assign ram_route_ext = expanded_mode && !ctl.onchip_ram_enable && ram_range_hit;

  // ----------------------------------------------------------------
  // NMI edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_prev_r <= 1'b1;
      nmi_req <= 1'b0;
    end else begin
      nmi_prev_r <= nmi_s;
      // No request on the first edge after release, old level not yet known
      nmi_req <= rst_seen_r && (ctl.nmi_edge_select ? (nmi_s && !nmi_prev_r)
                                                    : (!nmi_s && nmi_prev_r));
    end
  end

  // ----------------------------------------------------------------
  // Power state and settle counter
  // ----------------------------------------------------------------
  logic [17:0] settle_cnt_r;
  logic [17:0] settle_load;

  always_comb begin
    unique case (ctl.settle_sel)
      3'h0: settle_load = 18'(smc_pkg::SETTLE_0);
      3'h1: settle_load = 18'(smc_pkg::SETTLE_1);
      3'h2: settle_load = 18'(smc_pkg::SETTLE_2);
      3'h3: settle_load = 18'(smc_pkg::SETTLE_3);
      default: settle_load = 18'(smc_pkg::SETTLE_4);
    endcase
  end

  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      smc_pkg::SMC_RUN: begin
        if (sleep_exec) begin
          pwr_nxt = ctl.standby_select ? smc_pkg::SMC_STBY : smc_pkg::SMC_SLEEP;
        end
      end
      smc_pkg::SMC_SLEEP: begin
        if (ext_irq_wake || nmi_req) begin
          pwr_nxt = smc_pkg::SMC_RUN;
        end
      end
      smc_pkg::SMC_STBY: begin
        if (ext_irq_wake) begin
          pwr_nxt = smc_pkg::SMC_SETTLE;
        end
      end
      smc_pkg::SMC_SETTLE: begin
        if (settle_cnt_r == 18'h1) begin
          pwr_nxt = smc_pkg::SMC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_r <= smc_pkg::SMC_RUN;
      settle_cnt_r <= 18'h0;
    end else begin
      pwr_r <= pwr_nxt;
      if (pwr_r == smc_pkg::SMC_STBY) begin
        settle_cnt_r <= settle_load;
      end else if (settle_cnt_r != 18'h0) begin
        settle_cnt_r <= settle_cnt_r - 18'h1;
      end
    end
  end

  assign sleep_mode = pwr_r == smc_pkg::SMC_SLEEP;
  assign stby_mode = pwr_r == smc_pkg::SMC_STBY;
  assign cpu_hold = pwr_r != smc_pkg::SMC_RUN;

  // ----------------------------------------------------------------
  // Settle length watch
  // ----------------------------------------------------------------
  // Cycles spent settling against the field seen on entry
  logic [17:0] settle_len_r;
  logic [17:0] settle_want_r;
  wire [17:0] settle_want = ctl.settle_sel[2] ? 18'(smc_pkg::SETTLE_4)
    : 18'(smc_pkg::SETTLE_0) << ctl.settle_sel[1:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_len_r <= 18'h0;
      settle_want_r <= 18'h0;
    end else if (pwr_r == smc_pkg::SMC_STBY) begin
      settle_len_r <= 18'h0;
      settle_want_r <= settle_want;
    end else if (pwr_r == smc_pkg::SMC_SETTLE) begin
      settle_len_r <= settle_len_r + 18'h1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ctl_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctl_r & smc_pkg::SYSCTL_ONES) == smc_pkg::SYSCTL_ONES)
    else $error("Reserved control bits not one");
  sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pwr_r == smc_pkg::SMC_RUN && sleep_exec && !ctl.standby_select) |=> sleep_mode)
    else $error("Sleep not entered");
  stby_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pwr_r == smc_pkg::SMC_RUN && sleep_exec && ctl.standby_select) |=> stby_mode)
    else $error("Standby not entered");
  stby_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctl.standby_select && !wr_ctl) |=> ctl.standby_select)
    else $error("Standby select lost");
  settle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (stby_mode && ext_irq_wake && ctl.settle_sel == 3'h0) |=> cpu_hold [*8])
    else $error("Hold released early");
  nmi_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(nmi_s) && !ctl.nmi_edge_select && rst_seen_r) |=> nmi_req)
    else $error("Falling NMI missed");
  ram_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    onchip_ram_en == ctl_r[0])
    else $error("RAM enable mismatch");
  ram_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_r == 2'b01 && !ctl_r[0] && ram_range_hit) |-> ram_route_ext)
    else $error("RAM range not routed off chip");
  mode_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_rd & 8'hfc) == 8'he4)
    else $error("Mode fixed bits wrong");
  mode_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_mode |=> mode_r == $past(mode_pins_s))
    else $error("Mode pins not latched on read");
  settle_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pwr_r == smc_pkg::SMC_SETTLE && pwr_nxt == smc_pkg::SMC_RUN)
      |-> settle_len_r + 18'h1 == settle_want_r)
    else $error("Settle length wrong");
  settle_stay_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pwr_r == smc_pkg::SMC_SETTLE && settle_cnt_r != 18'h1) |=> cpu_hold)
    else $error("Settle left early");
  nmi_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(nmi_s) && ctl.nmi_edge_select && rst_seen_r) |=> nmi_req)
    else $error("Rising NMI missed");
  nmi_still_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$changed(nmi_s) |=> !nmi_req)
    else $error("NMI without edge");
  stby_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctl && !apb_req.pwdata[smc_pkg::STBY_BIT]) |=> !ctl.standby_select)
    else $error("Standby select not cleared");
  ram_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_ctl |=> $stable(ctl.onchip_ram_enable))
    else $error("RAM enable changed without write");
  mode_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rst_seen_r && !rd_mode) |=> $stable(mode_r))
    else $error("Mode bits changed without read");
  mode_init_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rst_seen_r |=> mode_r == $past(mode_pins_s))
    else $error("Mode pins not caught at reset");
  ctl_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit_ctl)
      |=> prdata == {24'h000000, $past(ctl_r)})
    else $error("Control read data wrong");

endmodule : smc_regs

// file: tb/smc_cpu_model.sv
// CPU-side register bus master model for the mode control registers.
// Assumes one pclk domain and an APB slave behind apb_req.
`timescale 1ns/1ns
module smc_cpu_model (
  // Bus
  input wire logic pclk,
  output smc_pkg::smc_apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial apb_req = '0;
  // One transfer: setup edge, access edge, wait for pready, return data and error
  task automatic xfer(input logic wr, input logic [17:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic err);
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, wr, a, {24'h000000, d}};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    // Released bus shows inverted address and write data
    apb_req <= '{1'b0, 1'b0, wr, ~a, ~{24'h000000, d}};
  endtask : xfer
endmodule : smc_cpu_model

// file: tb/tb_top.sv
// Self-checking bench for the system mode control registers.
// Assumes zero-wait APB and the CPU model as the only bus master.
`timescale 1ns/1ns
module tb_top;
  logic pclk, presetn, mode_pin_hi, mode_pin_lo, nmi_pin, sleep_exec, ext_irq_wake;
  logic ram_range_hit, pready, pslverr, nmi_req, cpu_hold, sleep_mode, stby_mode;
  logic onchip_ram_en, ram_route_ext, rom_enable, expanded_mode, mode_illegal, err;
  logic [31:0] prdata;
  logic [7:0] q, ctl_m;
  logic [15:0] lfsr_r = 16'h4182;
  smc_pkg::smc_apb_req_t apb_req;
  localparam logic [17:0] CTL = smc_pkg::SYSCTL_ADDR;
  localparam logic [17:0] MDR = smc_pkg::MODERB_ADDR;
  int bad_count = 0;
  int tests_run = 0;
  int n;

  smc_regs smc_regs_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_pin_hi(mode_pin_hi), .mode_pin_lo(mode_pin_lo),
    .nmi_pin(nmi_pin), .sleep_exec(sleep_exec), .ext_irq_wake(ext_irq_wake),
    .ram_range_hit(ram_range_hit), .nmi_req(nmi_req), .cpu_hold(cpu_hold),
    .sleep_mode(sleep_mode), .stby_mode(stby_mode), .onchip_ram_en(onchip_ram_en),
    .ram_route_ext(ram_route_ext), .rom_enable(rom_enable), .expanded_mode(expanded_mode),
    .mode_illegal(mode_illegal));
  smc_cpu_model smc_cpu_model_inst (.pclk(pclk), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic rd(input logic [17:0] a);
    smc_cpu_model_inst.xfer(1'b0, a, 8'h00, q, err);
  endtask : rd
  task automatic wr_ctl(input logic [7:0] d);
    ctl_m = (d & 8'hf5) | 8'h0a;
    smc_cpu_model_inst.xfer(1'b1, CTL, d, q, err);
  endtask : wr_ctl
  task automatic pulse(input logic wake);
    @(posedge pclk);
    ext_irq_wake <= wake;
    sleep_exec <= ~wake;
    @(posedge pclk);
    ext_irq_wake <= 1'b0;
    sleep_exec <= 1'b0;
    repeat (2) @(negedge pclk);
  endtask : pulse
  task automatic nmi_win(input logic lvl, input int exp);
    @(posedge pclk);
    nmi_pin <= lvl;
    n = 0;
    repeat (8) begin
      @(negedge pclk);
      n += nmi_req;
    end
    chk(n, exp);
  endtask : nmi_win

  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    presetn = 1'b0;
    {mode_pin_hi, mode_pin_lo} = 2'b11;
    {nmi_pin, sleep_exec, ext_irq_wake, ram_range_hit} = 4'h8;
    ctl_m = 8'h0b;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    nmi_win(1'b1, 0);
    rd(CTL);
    chk(q, ctl_m);
    chk({rom_enable, expanded_mode, mode_illegal}, 3'b100);
    rd(MDR);
    chk(q, 8'he7);
    $display("test reset done");
    repeat (8) begin
      lfsr_r = lfsr_next(lfsr_r);
      wr_ctl(lfsr_r[7:0]);
      rd(CTL);
      chk(q, ctl_m);
      chk(onchip_ram_en, ctl_m[0]);
    end
    smc_cpu_model_inst.xfer(1'b0, 18'h3ff18, 8'h00, q, err);
    chk({err, q}, 9'h100);
    $display("test control done");
    for (int m = 1; m < 4; m++) begin
      @(posedge pclk);
      {mode_pin_hi, mode_pin_lo} <= m[1:0];
      smc_cpu_model_inst.xfer(1'b1, MDR, 8'h1b, q, err);
      rd(MDR);
      chk(q, 8'he4 | m[7:0]);
      @(negedge pclk);
      chk({rom_enable, expanded_mode, mode_illegal}, {m[1], m != 3, 1'b0});
      wr_ctl(8'h00);
      ram_range_hit <= 1'b1;
      repeat (2) @(negedge pclk);
      chk(ram_route_ext, m != 3);
      @(posedge pclk);
      ram_range_hit <= 1'b0;
    end
    $display("test mode done");
    wr_ctl(8'h05);
    nmi_win(1'b0, 0);
    nmi_win(1'b1, 1);
    wr_ctl(8'h01);
    nmi_win(1'b0, 1);
    $display("test nmi done");
    pulse(1'b0);
    chk({sleep_mode, stby_mode, cpu_hold}, 3'b101);
    pulse(1'b1);
    chk(cpu_hold, 0);
    for (int c = 0; c < 2; c++) begin
      wr_ctl(8'h80 | c[7:0] << 4 | c[7:0]);
      pulse(1'b0);
      chk({sleep_mode, stby_mode, cpu_hold}, 3'b011);
      pulse(1'b1);
      n = 2;
      while (cpu_hold === 1'b1) begin
        @(negedge pclk);
        n++;
      end
      chk(n >= (8192 << c) - 2 && n <= (8192 << c) + 2, 1);
      rd(CTL);
      chk(q, ctl_m);
    end
    $display("test standby done");
    tally_and_finish();
  end
endmodule : tb_top
